/* File: verilog/lps_ctrl.sv */
// Low-power state control of an SDRAM device: self-refresh and power-down.
`timescale 1ns/1ps
module lps_ctrl (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic banks_open,
    input wire logic mode_slow_exit,
    output logic in_selfref,
    output logic in_powerdown,
    output logic active_pd,
    output logic input_buf_en,
    output logic dll_en,
    output logic int_clk_en,
    output logic refresh_tick,
    output logic cmd_ready,
    output logic read_ready,
    output logic illegal_cmd
);
    typedef struct packed {
        lps_pkg::lps_state_t state;
        logic cke_prev;
        logic slow_exit;
        logic [lps_pkg::CNT_W-1:0] exit_cnt;
        logic [lps_pkg::CNT_W-1:0] read_cnt;
        logic [lps_pkg::CNT_W-1:0] timer;
        logic refresh_tick;
        logic cmd_ready;
        logic read_ready;
        logic illegal;
        logic active_pd;
        logic dll_en;
        logic in_sr;
        logic in_pd;
        logic buf_en;
        logic clk_en;
    } lps_state_s_t;

    lps_state_s_t cur_ff;
    lps_state_s_t nxt_ff;
    lps_pkg::lps_cmd_t cmd;

    lps_cmd_decode u_dec (
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .cmd(cmd)
    );

    function automatic logic [lps_pkg::CNT_W-1:0] cyc(input int n);
        cyc = n[lps_pkg::CNT_W-1:0];
    endfunction

    function automatic logic [lps_pkg::CNT_W-1:0] dec_sat(input logic [lps_pkg::CNT_W-1:0] v);
        dec_sat = (v == lps_pkg::CNT_RESET) ? v : v - cyc(1);
    endfunction

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.cke_prev = cke;
        nxt_ff.refresh_tick = 1'b0;
        nxt_ff.illegal = 1'b0;
        nxt_ff.exit_cnt = dec_sat(cur_ff.exit_cnt);
        nxt_ff.read_cnt = dec_sat(cur_ff.read_cnt);
        case (cur_ff.state)
            lps_pkg::LPS_ACTIVE: begin
                nxt_ff.cmd_ready = (cur_ff.exit_cnt <= cyc(1));
                nxt_ff.read_ready = (cur_ff.read_cnt <= cyc(1));
                if (cur_ff.cke_prev && !cke) begin
                    if (cmd == lps_pkg::CMD_SELFREF && !banks_open) begin
                        // Self-timed refresh starts from a full timer period.
                        nxt_ff.state = lps_pkg::LPS_SELFREF;
                        nxt_ff.timer = cyc(lps_pkg::SELF_TIMER_PERIOD_CK);
                        nxt_ff.dll_en = 1'b0;
                        nxt_ff.cmd_ready = 1'b0;
                        nxt_ff.read_ready = 1'b0;
                    end else if (cmd == lps_pkg::CMD_NOP) begin
                        nxt_ff.active_pd = banks_open;
                        nxt_ff.slow_exit = mode_slow_exit;
                        nxt_ff.dll_en = banks_open && !mode_slow_exit;
                        nxt_ff.state = banks_open ? lps_pkg::LPS_APD : lps_pkg::LPS_PPD;
                        nxt_ff.cmd_ready = 1'b0;
                        nxt_ff.read_ready = 1'b0;
                    end else begin
                        nxt_ff.illegal = 1'b1;
                    end
                end
            end
            lps_pkg::LPS_SELFREF: begin
                // Only clock enable is watched here; the real part runs this timer off its own oscillator.
                nxt_ff.timer = (cur_ff.timer == lps_pkg::CNT_RESET) ?
                    cyc(lps_pkg::SELF_TIMER_PERIOD_CK) : cur_ff.timer - cyc(1);
                nxt_ff.refresh_tick = (cur_ff.timer == lps_pkg::CNT_RESET);
                if (cke) begin
                    nxt_ff.state = lps_pkg::LPS_SR_EXIT;
                    nxt_ff.exit_cnt = cyc(lps_pkg::SELFREF_EXIT_NONREAD_DELAY_CK);
                    nxt_ff.read_cnt = cyc(lps_pkg::SELFREF_EXIT_READ_DELAY_CK);
                    nxt_ff.dll_en = 1'b1;
                end
            end
            lps_pkg::LPS_SR_EXIT: begin
                if (!cke || cmd != lps_pkg::CMD_NOP) begin
                    nxt_ff.illegal = 1'b1;
                end
                if (cur_ff.exit_cnt <= cyc(1)) begin
                    nxt_ff.state = lps_pkg::LPS_ACTIVE;
                    nxt_ff.cmd_ready = 1'b1;
                end
            end
            lps_pkg::LPS_PPD, lps_pkg::LPS_APD: begin
                if (cke) begin
                    nxt_ff.state = lps_pkg::LPS_PD_EXIT;
                    nxt_ff.dll_en = 1'b1;
                    if (cmd != lps_pkg::CMD_NOP) begin
                        nxt_ff.illegal = 1'b1;
                    end
                    if (!cur_ff.active_pd) begin
                        nxt_ff.exit_cnt = cyc(lps_pkg::PRECHARGE_PD_EXIT_DELAY_CK);
                    end else if (cur_ff.slow_exit) begin
                        nxt_ff.exit_cnt = cyc(lps_pkg::SLOW_ACTIVE_EXIT_DELAY_CK);
                    end else begin
                        nxt_ff.exit_cnt = cyc(lps_pkg::FAST_ACTIVE_EXIT_DELAY_CK);
                    end
                    nxt_ff.read_cnt = nxt_ff.exit_cnt;
                end
            end
            lps_pkg::LPS_PD_EXIT: begin
                nxt_ff.active_pd = 1'b0;
                if (cur_ff.exit_cnt <= cyc(1)) begin
                    nxt_ff.state = lps_pkg::LPS_ACTIVE;
                    nxt_ff.cmd_ready = 1'b1;
                    nxt_ff.read_ready = 1'b1;
                end
            end
            default: begin
                nxt_ff.state = lps_pkg::LPS_ACTIVE;
            end
        endcase
        // Status pins follow the state being entered, so they switch on the same edge as the state itself.
        nxt_ff.in_sr = (nxt_ff.state == lps_pkg::LPS_SELFREF);
        nxt_ff.in_pd = (nxt_ff.state == lps_pkg::LPS_PPD) || (nxt_ff.state == lps_pkg::LPS_APD);
        nxt_ff.buf_en = !(nxt_ff.in_sr || nxt_ff.in_pd);
        nxt_ff.clk_en = !nxt_ff.in_sr;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur_ff.state <= lps_pkg::LPS_ACTIVE;
            cur_ff.cke_prev <= 1'b0;
            cur_ff.slow_exit <= 1'b0;
            cur_ff.exit_cnt <= lps_pkg::CNT_RESET;
            cur_ff.read_cnt <= lps_pkg::CNT_RESET;
            cur_ff.timer <= lps_pkg::CNT_RESET;
            cur_ff.refresh_tick <= 1'b0;
            cur_ff.cmd_ready <= 1'b1;
            cur_ff.read_ready <= 1'b1;
            cur_ff.illegal <= 1'b0;
            cur_ff.active_pd <= 1'b0;
            cur_ff.dll_en <= 1'b1;
            cur_ff.in_sr <= 1'b0;
            cur_ff.in_pd <= 1'b0;
            cur_ff.buf_en <= 1'b1;
            cur_ff.clk_en <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign in_selfref = cur_ff.in_sr;
    assign in_powerdown = cur_ff.in_pd;
    assign active_pd = cur_ff.active_pd;
    assign input_buf_en = cur_ff.buf_en;
    assign dll_en = cur_ff.dll_en;
    assign int_clk_en = cur_ff.clk_en;
    assign refresh_tick = cur_ff.refresh_tick;
    assign cmd_ready = cur_ff.cmd_ready;
    assign read_ready = cur_ff.read_ready;
    assign illegal_cmd = cur_ff.illegal;

    a_sr_entry: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_ACTIVE && cur_ff.cke_prev && !cke && !cs_n && !ras_n && !cas_n && we_n
        && !banks_open) |=> ##1 in_selfref) else $error("self-refresh not entered");
    a_sr_clock_off: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_SELFREF) |-> in_selfref && !int_clk_en && !input_buf_en)
        else $error("clock or buffers on in self-refresh");
    a_sr_no_bank: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_ACTIVE && banks_open) |=> cur_ff.state != lps_pkg::LPS_SELFREF)
        else $error("self-refresh with open bank");
    a_pd_entry: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_ACTIVE && cur_ff.cke_prev && !cke && cs_n) |=> ##1 in_powerdown)
        else $error("power-down not entered");
    a_pd_kind: assert property (@(posedge core_clk) disable iff (reset)
        $rose(in_powerdown) |-> active_pd == $past(banks_open)) else $error("wrong power-down kind");
    a_dll_fast: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_APD) |-> dll_en == !cur_ff.slow_exit)
        else $error("loop state wrong in active power-down");
    a_pd_exit_slow: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_APD && cur_ff.slow_exit && cke) |=> !cmd_ready [*7])
        else $error("slow exit too short");
    a_read_wait: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_SELFREF && cke) |=> !read_ready ##199 !read_ready ##1 read_ready)
        else $error("read exit delay wrong");
    a_nonread_wait: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_SELFREF && cke) |=> !cmd_ready ##17 !cmd_ready ##1 cmd_ready)
        else $error("non-read exit delay wrong");
    a_nop_idle: assert property (@(posedge core_clk) disable iff (reset)
        (cur_ff.state == lps_pkg::LPS_SR_EXIT && cke && cs_n) |=> !illegal_cmd)
        else $error("deselect flagged in exit");
endmodule

/* File: verilog/lps_pkg.sv */
// Constants and state encodings for the SDRAM low-power state control block.
package lps_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    // Read exit delay after self-refresh, in clock cycles.
    localparam int SELFREF_EXIT_READ_DELAY_CK = 200;
    // Extra time added to the refresh cycle time for the non-read exit delay, in ns.
    localparam int SELFREF_EXIT_EXTRA_NS = 10;
    localparam int SELFREF_EXIT_EXTRA_CK = (SELFREF_EXIT_EXTRA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Refresh cycle time, in ns; a plain default.
    localparam int REFRESH_CYCLE_TIME_NS = 128;
    localparam int REFRESH_CYCLE_TIME_CK = (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SELFREF_EXIT_NONREAD_DELAY_CK = REFRESH_CYCLE_TIME_CK + SELFREF_EXIT_EXTRA_CK;
    // Power-down exit delays in clock cycles; plain defaults.
    localparam int PRECHARGE_PD_EXIT_DELAY_CK = 2;
    localparam int FAST_ACTIVE_EXIT_DELAY_CK = 2;
    localparam int SLOW_ACTIVE_EXIT_DELAY_CK = 8;
    // Internal self-refresh timer reload value; refresh ticks come every 976 core clock cycles.
    localparam int SELF_TIMER_PERIOD_CK = 975;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
    localparam logic [7:0] NBANKS_OPEN_RESET = 8'h00;
    // Mode register bit that selects slow active power-down exit.
    localparam int MR_SLOW_EXIT_BIT = 12;

    typedef enum logic [5:0] {
        LPS_ACTIVE = 6'h01,
        LPS_SELFREF = 6'h02,
        LPS_SR_EXIT = 6'h04,
        LPS_PPD = 6'h08,
        LPS_APD = 6'h10,
        LPS_PD_EXIT = 6'h20
    } lps_state_t;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_SELFREF = 3'h1,
        CMD_MRS = 3'h2,
        CMD_READ = 3'h3,
        CMD_OTHER = 3'h4
    } lps_cmd_t;
endpackage

/* File: verilog/lps_cmd_decode.sv */
// Command decoder for chip select, row, column and write strobes.
`timescale 1ns/1ps
module lps_cmd_decode (
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    output lps_pkg::lps_cmd_t cmd
);
    always_comb begin
        if (cs_n) begin
            cmd = lps_pkg::CMD_NOP;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h7: cmd = lps_pkg::CMD_NOP;
                3'h1: cmd = lps_pkg::CMD_SELFREF;
                3'h0: cmd = lps_pkg::CMD_MRS;
                3'h5: cmd = lps_pkg::CMD_READ;
                default: cmd = lps_pkg::CMD_OTHER;
            endcase
        end
    end
endmodule

/* File: test/lps_mc_model.sv */
// Behavioural memory controller driving the clock-enable and command pins.
`timescale 1ns/1ps
module lps_mc_model (
    input wire logic core_clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n
);
    int hold_cnt = 3;
    // No termination pin is modelled, so termination is off at every self-refresh entry and clock change.
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
    end
    // One command per rising edge; a clock-enable change first waits out the minimum hold.
    task automatic drive(input logic k, input logic [3:0] c);
        while (k !== cke && hold_cnt < 3) begin
            @(negedge core_clk);
            {cs_n, ras_n, cas_n, we_n} = 4'h7;
            hold_cnt++;
        end
        @(negedge core_clk);
        hold_cnt = (k === cke) ? hold_cnt + 1 : 1;
        cke = k;
        {cs_n, ras_n, cas_n, we_n} = c;
    endtask
endmodule

/* File: test/lps_ctrl_tb_top.sv */
// Self-checking bench for the low-power state control block.
`timescale 1ns/1ps
module lps_ctrl_tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic banks_open = 1'b0;
    logic mode_slow_exit = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic in_selfref, in_powerdown, active_pd, input_buf_en, dll_en, int_clk_en;
    logic refresh_tick, cmd_ready, read_ready, illegal_cmd;
    logic [5:0] obs, obs_prev, m;
    logic exp_q [6][$];
    logic [31:0] rng = 32'h0000002F;
    int n_errors = 0;
    int samples_checked = 0;
    int ticks = 0;
    int illegals = 0;
    int lat, base, dly;

    lps_ctrl u_dut (.core_clk(core_clk), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .banks_open(banks_open), .mode_slow_exit(mode_slow_exit),
        .in_selfref(in_selfref), .in_powerdown(in_powerdown), .active_pd(active_pd),
        .input_buf_en(input_buf_en), .dll_en(dll_en), .int_clk_en(int_clk_en), .refresh_tick(refresh_tick),
        .cmd_ready(cmd_ready), .read_ready(read_ready), .illegal_cmd(illegal_cmd));
    lps_mc_model u_mc (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
    assign obs = {int_clk_en, dll_en, input_buf_en, active_pd, in_powerdown, in_selfref};

    // The clock never stops, so it is already stable whenever an exit is requested.
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Deselect leaves the strobes floating, so they get fresh random levels.
    function automatic logic [3:0] nop();
        logic [31:0] r;
        r = rnd();
        return r[0] ? {1'b1, r[3:1]} : 4'h7;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic note(input logic [5:0] mask, input logic [5:0] v);
        for (int i = 0; i < 6; i++) begin
            if (mask[i]) exp_q[i].push_back(v[i]);
        end
    endtask

    task automatic idle(input logic k, input int n);
        repeat (n) u_mc.drive(k, nop());
    endtask

    // Counts on from lat so the read delay is measured from the same exit edge.
    task automatic wait_ready(input int d, input logic rd);
        while ((rd ? read_ready : cmd_ready) !== 1'b1 && lat < 400) begin
            @(negedge core_clk);
            lat++;
        end
        check(rd ? "read delay" : "command delay", lat >= d && lat <= d + 4, 1'b1);
    endtask

    always @(negedge core_clk) begin
        if (!reset) begin
            ticks += (refresh_tick === 1'b1);
            illegals += (illegal_cmd === 1'b1);
            for (int i = 0; i < 6; i++) begin
                if (obs[i] !== obs_prev[i] && exp_q[i].size() == 0) check("unexpected change", i, 6);
                else if (obs[i] !== obs_prev[i]) check("state bit", obs[i], exp_q[i].pop_front());
            end
        end
        obs_prev = obs;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        results();
    end

    initial begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        check("reset outputs", {obs, cmd_ready, read_ready, refresh_tick, illegal_cmd}, 10'h38C);
        idle(1'b1, 4);
        note(6'h39, 6'h01);
        u_mc.drive(1'b0, 4'h1);
        base = ticks;
        repeat (2000) u_mc.drive(1'b0, 4'(rnd()));
        check("refresh ticks", ticks - base, 2);
        note(6'h39, 6'h38);
        lat = 0;
        u_mc.drive(1'b1, nop());
        wait_ready(lps_pkg::SELFREF_EXIT_NONREAD_DELAY_CK, 1'b0);
        wait_ready(lps_pkg::SELFREF_EXIT_READ_DELAY_CK, 1'b1);
        check("illegal pulses", illegals, 0);
        $display("test self-refresh done");
        for (int k = 0; k < 3; k++) begin
            banks_open = (k != 0);
            mode_slow_exit = (k == 2) | (k == 0 & rng[0]);
            dly = k == 0 ? lps_pkg::PRECHARGE_PD_EXIT_DELAY_CK : k == 1 ? lps_pkg::FAST_ACTIVE_EXIT_DELAY_CK
                : lps_pkg::SLOW_ACTIVE_EXIT_DELAY_CK;
            idle(1'b1, 3);
            m = 6'h0A | (k > 0 ? 6'h04 : 6'h00) | (k != 1 ? 6'h10 : 6'h00);
            note(m, k > 0 ? 6'h06 : 6'h02);
            u_mc.drive(1'b0, nop());
            idle(1'b0, 20);
            note(m, 6'h18);
            lat = 0;
            u_mc.drive(1'b1, nop());
            wait_ready(dly, 1'b0);
            $display("test power-down kind %0d done", k);
        end
        base = illegals;
        idle(1'b1, 3);
        u_mc.drive(1'b0, 4'h1);
        idle(1'b0, 3);
        idle(1'b1, 3);
        u_mc.drive(1'b0, 4'h5);
        idle(1'b0, 3);
        idle(1'b1, 6);
        check("refused entries", illegals - base, 2);
        $display("test refusals done");
        // A clock-enable loss in self-refresh is recovered only by re-initialising the block.
        banks_open = 1'b0;
        note(6'h39, 6'h01);
        u_mc.drive(1'b0, 4'h1);
        idle(1'b0, 3);
        reset = 1'b1;
        idle(1'b1, 3);
        reset = 1'b0;
        check("re-init outputs", {obs, cmd_ready, read_ready, refresh_tick, illegal_cmd}, 10'h38C);
        idle(1'b1, 3);
        foreach (exp_q[i]) check("pending notes", exp_q[i].size(), 0);
        $display("test re-initialisation done");
        results();
    end
endmodule
